// [rtl/htrs_top.sv]
// Role selection for the two halves of a link port, with AXI4-Lite registers
// Notes on behaviour
// RQ1: With the low master strap at 1 the low half is master and drives its sideband lines.
// RQ2: In master role the low sideband lines are two-way pins with output enables.
// RQ3: In master role the high sideband lines are likewise two-way pins.
// RQ4: Each slave flag resets to the inverse of its half's master strap.
// RQ5: Outgoing packets carry bridge bit 1 while the slave flag is 0, else 0.
// RQ6: With the slave flag at 0 a request missing all windows goes back as peer-to-peer.
// RQ7: With the slave flag at 1 a request missing all windows gets an error answer.
// RQ8: With the low master strap at 0 the low sideband lines are only received.
// RQ9: A half in slave role relies on the peer driving its sideband lines correctly.
// RQ10: With the high master strap and the split strap at 1 the high half drives its sideband lines.
// RQ11: With the high master strap at 0 the high sideband lines are only received.
// RQ12: With the split strap at 0 the port is one wide link and high signals are ignored.
// RQ13: Straps are sampled in reset and roles and enables hold until the next reset.
`timescale 1ns/1ps
module htrs_top import htrs_pkg::*; (
    input wire logic aclk, // Controller clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic ce, // Clock enable for the controller domain
    input wire logic link_clk, // Link clock
    input wire logic [HTRS_AW-1:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [HTRS_AW-1:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic low_half_master_strap, // Low half role strap
    input wire logic high_half_master_strap, // High half role strap
    input wire logic split_width_strap, // Two narrow links when 1
    input wire logic low_half_power_good_i, // Low power-good pin level
    output logic low_half_power_good_o, // Low power-good drive value
    output logic low_half_power_good_oe_n, // Low power-good enable, low drives
    input wire logic low_half_link_reset_n_i, // Low link reset pin level
    output logic low_half_link_reset_n_o, // Low link reset drive value
    output logic low_half_link_reset_n_oe_n, // Low link reset enable, low drives
    input wire logic low_half_link_stop_n_i, // Low link stop pin level
    output logic low_half_link_stop_n_o, // Low link stop drive value
    output logic low_half_link_stop_n_oe_n, // Low link stop enable, low drives
    input wire logic high_half_power_good_i, // High power-good pin level
    output logic high_half_power_good_o, // High power-good drive value
    output logic high_half_power_good_oe_n, // High power-good enable, low drives
    input wire logic high_half_link_reset_n_i, // High link reset pin level
    output logic high_half_link_reset_n_o, // High link reset drive value
    output logic high_half_link_reset_n_oe_n, // High link reset enable, low drives
    input wire logic high_half_link_stop_n_i, // High link stop pin level
    output logic high_half_link_stop_n_o, // High link stop drive value
    output logic high_half_link_stop_n_oe_n, // High link stop enable, low drives
    input wire logic low_req_valid, // Low half incoming request, link clock
    input wire logic low_req_win_hit, // Low half request hits a window
    output logic low_fwd_p2p, // Low half forward pulse, link clock
    output logic low_err_rsp, // Low half error pulse, link clock
    output logic low_bridge_bit, // Low half bridge bit, link clock
    input wire logic high_req_valid, // High half incoming request, link clock
    input wire logic high_req_win_hit, // High half request hits a window
    output logic high_fwd_p2p, // High half forward pulse, link clock
    output logic high_err_rsp, // High half error pulse, link clock
    output logic high_bridge_bit // High half bridge bit, link clock
);
    typedef struct packed {
        logic [2:0] strap;
        logic [1:0] slv;
        logic [2:0] lo_drv;
        logic [2:0] hi_drv;
        logic [2:0] lo_oen;
        logic [2:0] hi_oen;
        logic awv;
        logic [HTRS_AW-1:0] awa;
        logic wv;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awr;
        logic wr;
        logic bv;
        logic [1:0] br;
        logic arr;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } htrs_top_st_t;

    htrs_top_st_t q;
    htrs_top_st_t d;
    logic [8:0] pins_s;
    logic [2:0] strap_s;
    logic [2:0] lo_pin;
    logic [2:0] hi_pin;
    logic [31:0] ctrl_w;
    logic [31:0] stat_w;
    logic wr_fire;
    htrs_sel_t wsel;
    htrs_sel_t rsel;

    htrs_sync #(
        .W(9)
    ) u_pin_sync (
        .clk(aclk),
        .ce(ce),
        .din({high_half_link_stop_n_i, high_half_link_reset_n_i, high_half_power_good_i,
              low_half_link_stop_n_i, low_half_link_reset_n_i, low_half_power_good_i,
              split_width_strap, high_half_master_strap, low_half_master_strap}),
        .dout(pins_s)
    );

    assign strap_s = pins_s[2:0];
    assign lo_pin = pins_s[5:3]; // RQ9
    // High pins mean nothing on a single wide link
    assign hi_pin = pins_s[8:6] & {3{q.strap[2]}}; // RQ12

    assign ctrl_w = {24'h00_0000, q.hi_drv, q.lo_drv, q.slv};
    assign stat_w = {21'h0_0000, q.hi_oen == HTRS_OEN_ON, q.lo_oen == HTRS_OEN_ON,
                     hi_pin, lo_pin, q.strap};

    assign wr_fire = q.awv && q.wv && !q.bv;
    assign wsel = htrs_decode(q.awa);
    assign rsel = htrs_decode(araddr);

    always_comb begin
        d = q;
        if (!aresetn) begin
            d = '0;
            // Roles are caught from the straps while reset is held
            d.strap = strap_s; // RQ13
            d.slv = ~strap_s[1:0]; // RQ4
            d.lo_drv = HTRS_DRV_RST;
            d.hi_drv = HTRS_DRV_RST;
            d.lo_oen = strap_s[0] ? HTRS_OEN_ON : HTRS_OEN_OFF; // RQ1 RQ8
            if (strap_s[1] && strap_s[2]) begin
                d.hi_oen = HTRS_OEN_ON; // RQ10
            end else begin
                d.hi_oen = HTRS_OEN_OFF; // RQ11
            end
            d.awr = 1'b1;
            d.wr = 1'b1;
            d.arr = 1'b1;
        end else begin
            if (q.awr && awvalid) begin
                d.awv = 1'b1;
                d.awa = awaddr;
            end
            if (q.wr && wvalid) begin
                d.wv = 1'b1;
                d.wd = wdata;
                d.ws = wstrb;
            end
            if (q.bv && bready) begin
                d.bv = 1'b0;
            end
            if (wr_fire) begin
                d.awv = 1'b0;
                d.wv = 1'b0;
                d.bv = 1'b1;
                d.br = HTRS_RESP_OKAY;
                case (wsel)
                    HTRS_SEL_CTRL: begin
                        if (q.ws[0]) begin
                            d.slv = q.wd[HTRS_SLV_LSB +: 2];
                            d.lo_drv = q.wd[HTRS_LDRV_LSB +: 3]; // RQ1
                            d.hi_drv = q.wd[HTRS_HDRV_LSB +: 3]; // RQ10
                        end
                    end
                    // Status is read-only; writes are accepted and dropped
                    HTRS_SEL_STAT: d.br = HTRS_RESP_OKAY;
                    default: d.br = HTRS_RESP_SLVERR;
                endcase
            end
            // One write is held at a time; a new one waits until both halves clear
            d.awr = !d.awv;
            d.wr = !d.wv;
            if (q.rv && rready) begin
                d.rv = 1'b0;
            end
            if (q.arr && arvalid) begin
                d.rv = 1'b1;
                d.rr = HTRS_RESP_OKAY;
                case (rsel)
                    HTRS_SEL_CTRL: d.rd = ctrl_w;
                    HTRS_SEL_STAT: d.rd = stat_w;
                    default: begin
                        d.rd = 32'h0000_0000;
                        d.rr = HTRS_RESP_SLVERR;
                    end
                endcase
            end
            d.arr = !d.rv;
        end
    end

    // Reset wins over a low clock enable; the straps caught are the synchroniser outputs, which freeze while ce is low
    always_ff @(posedge aclk) begin
        if (ce || !aresetn) begin
            q <= d;
        end
    end

    assign awready = q.awr;
    assign wready = q.wr;
    assign bvalid = q.bv;
    assign bresp = q.br;
    assign arready = q.arr;
    assign rvalid = q.rv;
    assign rdata = q.rd;
    assign rresp = q.rr;

    // Drive values always come from flops; the enables decide if they reach the wire
    assign low_half_power_good_o = q.lo_drv[0];
    assign low_half_link_reset_n_o = q.lo_drv[1];
    assign low_half_link_stop_n_o = q.lo_drv[2];
    assign low_half_power_good_oe_n = q.lo_oen[0]; // RQ2
    assign low_half_link_reset_n_oe_n = q.lo_oen[1]; // RQ2
    assign low_half_link_stop_n_oe_n = q.lo_oen[2]; // RQ2
    assign high_half_power_good_o = q.hi_drv[0];
    assign high_half_link_reset_n_o = q.hi_drv[1];
    assign high_half_link_stop_n_o = q.hi_drv[2];
    assign high_half_power_good_oe_n = q.hi_oen[0]; // RQ3
    assign high_half_link_reset_n_oe_n = q.hi_oen[1]; // RQ3
    assign high_half_link_stop_n_oe_n = q.hi_oen[2]; // RQ3

    htrs_link_half u_low (
        .link_clk(link_clk),
        .aresetn(aresetn),
        .slave_flag(q.slv[0]),
        .half_en(1'b1),
        .req_valid(low_req_valid),
        .req_win_hit(low_req_win_hit),
        .fwd_p2p(low_fwd_p2p),
        .err_rsp(low_err_rsp),
        .bridge_bit(low_bridge_bit)
    );

    htrs_link_half u_high (
        .link_clk(link_clk),
        .aresetn(aresetn),
        .slave_flag(q.slv[1]),
        .half_en(q.strap[2]), // RQ12
        .req_valid(high_req_valid),
        .req_win_hit(high_req_win_hit),
        .fwd_p2p(high_fwd_p2p),
        .err_rsp(high_err_rsp),
        .bridge_bit(high_bridge_bit)
    );

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_lo_master_drive; // RQ1
        (ce && wr_fire && wsel == HTRS_SEL_CTRL && q.ws[0] && q.strap[0])
        |=> (low_half_power_good_o == $past(q.wd[HTRS_LDRV_LSB])
             && low_half_power_good_oe_n == 1'b0);
    endproperty
    a_lo_master_drive: assert property (p_lo_master_drive) else $error("low drive not applied");

    property p_lo_master_pins; // RQ2
        q.strap[0] |-> (q.lo_oen == HTRS_OEN_ON);
    endproperty
    a_lo_master_pins: assert property (p_lo_master_pins) else $error("low master not driving");

    property p_hi_master_pins; // RQ3
        (q.strap[1] && q.strap[2]) |-> (q.hi_oen == HTRS_OEN_ON);
    endproperty
    a_hi_master_pins: assert property (p_hi_master_pins) else $error("high master not driving");

    property p_slave_init; // RQ4
        $rose(aresetn) |-> (q.slv == ~q.strap[1:0]);
    endproperty
    a_slave_init: assert property (p_slave_init) else $error("slave flag reset wrong");

    property p_lo_slave_quiet; // RQ8
        !q.strap[0] |-> (q.lo_oen == HTRS_OEN_OFF);
    endproperty
    a_lo_slave_quiet: assert property (p_lo_slave_quiet) else $error("low slave drives pins");

    property p_hi_master_drive; // RQ10
        (ce && wr_fire && wsel == HTRS_SEL_CTRL && q.ws[0] && q.strap[1] && q.strap[2])
        |=> (high_half_link_stop_n_o == $past(q.wd[HTRS_HDRV_LSB + 2])
             && high_half_link_stop_n_oe_n == 1'b0);
    endproperty
    a_hi_master_drive: assert property (p_hi_master_drive) else $error("high drive not applied");

    property p_hi_slave_quiet; // RQ11
        !q.strap[1] |-> (q.hi_oen == HTRS_OEN_OFF);
    endproperty
    a_hi_slave_quiet: assert property (p_hi_slave_quiet) else $error("high slave drives pins");

    property p_wide_ignores_high; // RQ12
        !q.strap[2] |-> (q.hi_oen == HTRS_OEN_OFF && hi_pin == 3'h0);
    endproperty
    a_wide_ignores_high: assert property (p_wide_ignores_high) else $error("high used when wide");

    property p_roles_hold; // RQ13
        $past(aresetn) |-> ($stable(q.strap) && $stable(q.lo_oen) && $stable(q.hi_oen));
    endproperty
    a_roles_hold: assert property (p_roles_hold) else $error("roles changed outside reset");

    property p_slave_write;
        (ce && wr_fire && wsel == HTRS_SEL_CTRL && q.ws[0])
        |=> (q.slv == $past(q.wd[HTRS_SLV_LSB +: 2]));
    endproperty
    a_slave_write: assert property (p_slave_write) else $error("flag write lost");

    property p_bresp_hold;
        (bvalid && !bready) |=> (bvalid && $stable(bresp));
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("bresp dropped");

    property p_rdata_hold;
        (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp));
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata dropped");

    property p_drive_init; // RQ1 RQ10
        $rose(aresetn) |-> (q.lo_drv == HTRS_DRV_RST && q.hi_drv == HTRS_DRV_RST);
    endproperty
    a_drive_init: assert property (p_drive_init) else $error("drive not reset");

    property p_ce_freeze;
        !ce |=> $stable(q);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("moved while disabled");

    property p_rd_unmapped;
        (ce && arvalid && arready && rsel == HTRS_SEL_NONE)
        |=> (rresp == HTRS_RESP_SLVERR && rdata == 32'h0000_0000);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");

    property p_aw_taken;
        (ce && awvalid && awready) |=> !awready;
    endproperty
    a_aw_taken: assert property (p_aw_taken) else $error("address taken twice");
endmodule

// [rtl/htrs_pkg.sv]
// Shared constants, register map and decode helper for the link role selector
package htrs_pkg;
    localparam int HTRS_AW = 4;
    localparam logic [3:0] HTRS_CTRL_OFF = 4'h0;
    localparam logic [3:0] HTRS_STAT_OFF = 4'h4;
    // Control register fields
    localparam int HTRS_SLV_LSB = 0;
    localparam int HTRS_LDRV_LSB = 2;
    localparam int HTRS_HDRV_LSB = 5;
    // Status register fields
    localparam int HTRS_STRAP_LSB = 0;
    localparam int HTRS_LPIN_LSB = 3;
    localparam int HTRS_HPIN_LSB = 6;
    localparam int HTRS_LMST_BIT = 9;
    localparam int HTRS_HMST_BIT = 10;
    // Sideband drive bits {stop_n, reset_n, power_good}: link held in reset
    localparam logic [2:0] HTRS_DRV_RST = 3'h4;
    localparam logic [2:0] HTRS_OEN_ON = 3'h0;
    localparam logic [2:0] HTRS_OEN_OFF = 3'h7;
    localparam logic [1:0] HTRS_RESP_OKAY = 2'h0;
    localparam logic [1:0] HTRS_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        HTRS_SEL_NONE = 3'b001,
        HTRS_SEL_CTRL = 3'b010,
        HTRS_SEL_STAT = 3'b100
    } htrs_sel_t;

    function automatic htrs_sel_t htrs_decode(input logic [HTRS_AW-1:0] a);
        case (a)
            HTRS_CTRL_OFF: htrs_decode = HTRS_SEL_CTRL;
            HTRS_STAT_OFF: htrs_decode = HTRS_SEL_STAT;
            default: htrs_decode = HTRS_SEL_NONE;
        endcase
    endfunction
endpackage

// [rtl/htrs_sync.sv]
// Two-stage synchroniser for pin levels entering the controller clock domain
`timescale 1ns/1ps
module htrs_sync import htrs_pkg::*; #(
    parameter int W = 9
) (
    input wire logic clk, // Destination clock
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] din, // Asynchronous levels
    output logic [W-1:0] dout // Synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } htrs_sync_st_t;

    htrs_sync_st_t q;
    htrs_sync_st_t d;

    // No reset: straps must keep flowing while the block is held in reset
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule

// [rtl/htrs_link_half.sv]
// Link-clock logic of one half: bridge bit and handling of window misses
`timescale 1ns/1ps
module htrs_link_half import htrs_pkg::*; (
    input wire logic link_clk, // Link clock
    input wire logic aresetn, // Controller reset, synchronised here
    input wire logic slave_flag, // Slave_role_flag flag, controller domain
    input wire logic half_en, // Half in use, controller domain
    input wire logic req_valid, // Incoming request this cycle
    input wire logic req_win_hit, // Request address hits a receive window
    output logic fwd_p2p, // Pulse: send request back as peer-to-peer
    output logic err_rsp, // Pulse: answer request with error
    output logic bridge_bit // Bridge bit for outgoing packets
);
    typedef struct packed {
        logic rs1;
        logic rs2;
        logic [1:0] f1;
        logic [1:0] f2;
        logic br;
        logic fwd;
        logic err;
    } htrs_half_st_t;

    htrs_half_st_t q;
    htrs_half_st_t d;
    logic miss;

    assign miss = req_valid && !req_win_hit && q.f2[1];

    always_comb begin
        d = q;
        d.rs1 = aresetn;
        d.rs2 = q.rs1;
        // Flags are static flops in the other domain, so a plain level sync is safe
        d.f1 = {half_en, slave_flag};
        d.f2 = q.f1;
        if (!q.rs2) begin
            d.br = 1'b0;
            d.fwd = 1'b0;
            d.err = 1'b0;
        end else begin
            d.br = !q.f2[0]; // RQ5
            d.fwd = miss && !q.f2[0]; // RQ6
            d.err = miss && q.f2[0]; // RQ7
        end
    end

    always_ff @(posedge link_clk) begin
        q <= d;
    end

    assign fwd_p2p = q.fwd;
    assign err_rsp = q.err;
    assign bridge_bit = q.br;

    property p_fwd_miss; // RQ6
        @(posedge link_clk) disable iff (!q.rs2)
        (q.f2 == 2'b10 && req_valid && !req_win_hit) |=> (fwd_p2p && !err_rsp);
    endproperty
    a_fwd_miss: assert property (p_fwd_miss) else $error("miss not forwarded as master");

    property p_err_miss; // RQ7
        @(posedge link_clk) disable iff (!q.rs2)
        (q.f2 == 2'b11 && req_valid && !req_win_hit) |=> (err_rsp && !fwd_p2p);
    endproperty
    a_err_miss: assert property (p_err_miss) else $error("miss not answered with error");

    property p_hit_quiet; // RQ6
        @(posedge link_clk) disable iff (!q.rs2)
        (req_valid && req_win_hit) |=> !(fwd_p2p || err_rsp);
    endproperty
    a_hit_quiet: assert property (p_hit_quiet) else $error("window hit treated as miss");

    property p_bridge; // RQ5
        @(posedge link_clk) disable iff (!q.rs2)
        (q.f2[0] ##1 q.f2[0]) |-> !bridge_bit;
    endproperty
    a_bridge: assert property (p_bridge) else $error("bridge bit set while slave");
endmodule

// [testbench/htrs_peer.sv]
// Far-side peer model: drives the sideband lines that the device leaves undriven
`timescale 1ns/1ps
module htrs_peer (
    input wire logic link_clk, // Link clock, paces the floating pattern
    input wire logic [5:0] dut_o, // Device drive values
    input wire logic [5:0] dut_oe_n, // Device enables, low drives
    input wire logic peer_en, // Peer drives lines the device releases
    input wire logic [5:0] peer_val, // Peer drive values
    output logic [5:0] pin // Resolved line levels
);
    logic [5:0] float_q = 6'h15;

    // No pull on these lines, so an undriven line keeps changing instead of holding
    always @(posedge link_clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!dut_oe_n[i]) begin
                pin[i] = dut_o[i];
            end else if (peer_en) begin
                pin[i] = peer_val[i];
            end else begin
                pin[i] = float_q[i];
            end
        end
    end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the link role selector
`timescale 1ns/1ps
module testbench;
    import htrs_pkg::*;
    logic aclk = 1'b0, link_clk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [HTRS_AW-1:0] awaddr = 4'h0, araddr = 4'h0;
    logic [3:0] wstrb = 4'hf;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic lo_strap = 1'b1, hi_strap = 1'b1, split_strap = 1'b1, peer_en = 1'b0;
    logic [5:0] pin, drv_o, drv_oe_n;
    logic [5:0] peer_val = 6'h2d;
    logic lo_req = 1'b0, lo_hit = 1'b0, hi_req = 1'b0, hi_hit = 1'b0;
    logic lo_fwd, lo_err, lo_bb, hi_fwd, hi_err, hi_bb;
    int miscompares = 0, tests_run = 0;

    always #10 aclk = ~aclk;
    always #32 link_clk = ~link_clk;

    htrs_top i_htrs_top (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .link_clk(link_clk),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .low_half_master_strap(lo_strap), .high_half_master_strap(hi_strap),
        .split_width_strap(split_strap),
        .low_half_power_good_i(pin[0]), .low_half_power_good_o(drv_o[0]),
        .low_half_power_good_oe_n(drv_oe_n[0]), .low_half_link_reset_n_i(pin[1]),
        .low_half_link_reset_n_o(drv_o[1]), .low_half_link_reset_n_oe_n(drv_oe_n[1]),
        .low_half_link_stop_n_i(pin[2]), .low_half_link_stop_n_o(drv_o[2]),
        .low_half_link_stop_n_oe_n(drv_oe_n[2]),
        .high_half_power_good_i(pin[3]), .high_half_power_good_o(drv_o[3]),
        .high_half_power_good_oe_n(drv_oe_n[3]), .high_half_link_reset_n_i(pin[4]),
        .high_half_link_reset_n_o(drv_o[4]), .high_half_link_reset_n_oe_n(drv_oe_n[4]),
        .high_half_link_stop_n_i(pin[5]), .high_half_link_stop_n_o(drv_o[5]),
        .high_half_link_stop_n_oe_n(drv_oe_n[5]),
        .low_req_valid(lo_req), .low_req_win_hit(lo_hit), .low_fwd_p2p(lo_fwd),
        .low_err_rsp(lo_err), .low_bridge_bit(lo_bb),
        .high_req_valid(hi_req), .high_req_win_hit(hi_hit), .high_fwd_p2p(hi_fwd),
        .high_err_rsp(hi_err), .high_bridge_bit(hi_bb)
    );

    htrs_peer i_htrs_peer (
        .link_clk(link_clk), .dut_o(drv_o), .dut_oe_n(drv_oe_n), .peer_en(peer_en),
        .peer_val(peer_val), .pin(pin)
    );

    task automatic results();
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timeout();
        chk("wait bound", 32'h0000_0001, 32'h0000_0000);
        results();
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, bresp});
                break;
            end
        end
        if (n == 40) timeout();
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                rready <= 1'b0;
                d = rdata;
                chk("rresp", {30'h0, er}, {30'h0, rresp});
                break;
            end
        end
        if (n == 40) timeout();
    endtask

    // Outcome coded {forward, error}; pulses are gathered over three link cycles
    task automatic link_req(input logic hi, input logic hit, input logic [1:0] exp);
        logic [1:0] seen;
        seen = 2'h0;
        @(posedge link_clk);
        lo_req <= !hi;
        hi_req <= hi;
        lo_hit <= hit;
        hi_hit <= hit;
        @(posedge link_clk);
        lo_req <= 1'b0;
        hi_req <= 1'b0;
        repeat (3) begin
            #1;
            seen = seen | (hi ? {hi_fwd, hi_err} : {lo_fwd, lo_err});
            @(posedge link_clk);
        end
        chk(hi ? "high request" : "low request", {30'h0, exp}, {30'h0, seen});
    endtask

    // Held past four link edges so the link-side reset synchroniser sees it
    task automatic do_reset(input logic lo, input logic hi, input logic sp, input logic pe);
        @(posedge aclk);
        aresetn <= 1'b0;
        lo_strap <= lo;
        hi_strap <= hi;
        split_strap <= sp;
        peer_en <= pe;
        repeat (14) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge link_clk);
    endtask

    initial begin
        #400000;
        timeout();
    end

    initial begin
        // Both halves master, two narrow links
        do_reset(1'b1, 1'b1, 1'b1, 1'b0);
        chk("oe_n", 32'h0000_0000, {26'h0, drv_oe_n});
        chk("drive", 32'h0000_0024, {26'h0, drv_o});
        axi_rd(HTRS_CTRL_OFF, HTRS_RESP_OKAY, rd);
        chk("ctrl", 32'h0000_0090, rd);
        axi_rd(HTRS_STAT_OFF, HTRS_RESP_OKAY, rd);
        chk("stat", 32'h0000_0607, rd & 32'h0000_0607);
        chk("bridge", 32'h0000_0003, {30'h0, hi_bb, lo_bb});
        link_req(1'b0, 1'b0, 2'b10);
        link_req(1'b0, 1'b1, 2'b00);
        link_req(1'b1, 1'b0, 2'b10);
        // Low flag set, all lines released high
        axi_wr(HTRS_CTRL_OFF, 32'h0000_00fd, HTRS_RESP_OKAY);
        repeat (6) @(posedge link_clk);
        chk("bridge", 32'h0000_0002, {30'h0, hi_bb, lo_bb});
        link_req(1'b0, 1'b0, 2'b01);
        link_req(1'b1, 1'b0, 2'b10);
        chk("drive", 32'h0000_003f, {26'h0, drv_o});
        chk("oe_n", 32'h0000_0000, {26'h0, drv_oe_n});
        axi_wr(4'h8, 32'h0000_0000, HTRS_RESP_SLVERR);
        axi_rd(4'h8, HTRS_RESP_SLVERR, rd);
        chk("unmapped", 32'h0000_0000, rd);
        axi_wr(HTRS_STAT_OFF, 32'hffff_ffff, HTRS_RESP_OKAY);
        axi_rd(HTRS_STAT_OFF, HTRS_RESP_OKAY, rd);
        chk("stat", 32'h0000_0607, rd & 32'h0000_0607);
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        ce <= 1'b1;
        wstrb <= 4'he;
        axi_wr(HTRS_CTRL_OFF, 32'h0000_0000, HTRS_RESP_OKAY);
        wstrb <= 4'hf;
        axi_rd(HTRS_CTRL_OFF, HTRS_RESP_OKAY, rd);
        chk("ctrl", 32'h0000_00fd, rd);
        // Both halves slave, peer drives the lines
        do_reset(1'b0, 1'b0, 1'b1, 1'b1);
        chk("oe_n", 32'h0000_003f, {26'h0, drv_oe_n});
        axi_rd(HTRS_CTRL_OFF, HTRS_RESP_OKAY, rd);
        chk("ctrl", 32'h0000_0093, rd);
        chk("bridge", 32'h0000_0000, {30'h0, hi_bb, lo_bb});
        link_req(1'b0, 1'b0, 2'b01);
        link_req(1'b1, 1'b1, 2'b00);
        axi_rd(HTRS_STAT_OFF, HTRS_RESP_OKAY, rd);
        chk("stat", 32'h0000_016c, rd & 32'h0000_07ff);
        @(posedge aclk);
        lo_strap <= 1'b1;
        hi_strap <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("oe_n", 32'h0000_003f, {26'h0, drv_oe_n});
        axi_rd(HTRS_STAT_OFF, HTRS_RESP_OKAY, rd);
        chk("stat", 32'h0000_0004, rd & 32'h0000_0607);
        // One wide link, high half unused
        do_reset(1'b1, 1'b1, 1'b0, 1'b1);
        chk("oe_n", 32'h0000_0038, {26'h0, drv_oe_n});
        link_req(1'b1, 1'b0, 2'b00);
        link_req(1'b0, 1'b0, 2'b10);
        axi_rd(HTRS_STAT_OFF, HTRS_RESP_OKAY, rd);
        chk("stat", 32'h0000_0203, rd & 32'h0000_07c7);
        results();
    end
endmodule
